// *** core/sspc_pkg.sv ***
// Overview of operation
// - The sidestream carries samples only while bit 7 of the control register is 1.
// - The sidestream is silenced while mute bit 6 is 1, which is its state after reset.
// - A 2-bit selector picks the source: 0 ADC1 left, 1 ADC1 right, 2 ADC2 left, 3 ADC2 right.
// - A 5-bit gain code runs from -42 dB at 00000 in 1.5 dB steps, unity at 11100.
// - The left output mixes left filter (bit 0), right filter (bit 1), sidestream (bit 2).
// - The right output has its own mask with the same bit meanings.
// - The coefficient data register holds the byte to store and is loaded before the address.
// - A 5-bit byte index writes the low byte of a 16-bit coefficient when even, high when odd.
// - Each write of the index register stores the held data byte; the data write stores nothing.
package sspc_pkg;
    localparam int SAMPLE_W = 24;
    localparam int GAIN_W = 16;
    localparam int GAIN_FRAC = 14;
    localparam int COEF_NUM = 16;

    localparam logic [7:0] OFS_CONTROL = 8'he4;
    localparam logic [7:0] OFS_SOURCE = 8'he5;
    localparam logic [7:0] OFS_LEVEL = 8'he6;
    localparam logic [7:0] OFS_LEFT_ROUTE = 8'he8;
    localparam logic [7:0] OFS_RIGHT_ROUTE = 8'he9;
    localparam logic [7:0] OFS_COEF_DATA = 8'hea;
    localparam logic [7:0] OFS_COEF_INDEX = 8'heb;

    localparam int BIT_PATH_ON = 7;
    localparam int BIT_MUTE = 6;
    localparam int MASK_LEFT_FILT = 0;
    localparam int MASK_RIGHT_FILT = 1;
    localparam int MASK_SIDE = 2;

    localparam logic [1:0] RST_PATH_CTRL = 2'h1;
    localparam logic [1:0] RST_SOURCE = 2'h0;
    localparam logic [4:0] RST_LEVEL = 5'h1c;
    localparam logic [2:0] RST_LEFT_ROUTE = 3'h1;
    localparam logic [2:0] RST_RIGHT_ROUTE = 3'h2;
    localparam logic [7:0] RST_COEF_DATA = 8'h00;
    localparam logic [4:0] RST_COEF_INDEX = 5'h00;

    // linear gain in unsigned q2.14, index is the 5-bit level code
    localparam logic [15:0] GAIN_TABLE [32] = '{
        16'h0082, 16'h009a, 16'h00b8, 16'h00da, 16'h0103, 16'h0134, 16'h016f, 16'h01b4,
        16'h0206, 16'h0267, 16'h02db, 16'h0365, 16'h0409, 16'h04cc, 16'h05b4, 16'h06c7,
        16'h080e, 16'h0993, 16'h0b61, 16'h0d86, 16'h1013, 16'h131b, 16'h16b5, 16'h1afc,
        16'h2013, 16'h261f, 16'h2d4f, 16'h35d9, 16'h4000, 16'h4c11, 16'h5a67, 16'h6b71
    };
endpackage

// *** core/sspc_top.sv ***
`timescale 1ns/1ns
// output buffer, depth must be a power of two
module sspc_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW:0]      wr_ptr;
    logic [PW:0]      rd_ptr;
    logic [PW:0]      next_wr_ptr;
    logic [PW:0]      next_rd_ptr;
    logic             push;
    logic             pop;

    // full when pointers differ only in the wrap bit
    always_comb
    begin
        in_ready = !((wr_ptr[PW] != rd_ptr[PW]) && (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]));
        out_valid = (wr_ptr != rd_ptr);
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        out_data = store[rd_ptr[PW-1:0]];
    end

    // storage has no reset; only pointers carry control state
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
        if (push)
            store[wr_ptr[PW-1:0]] <= in_data;
    end
endmodule

module sspc_top #(
    parameter int FIFO_DEPTH = 4
) (
    // clock and reset
    input  wire logic                            clk,
    input  wire logic                            reset,
    // register port from the control interface
    input  wire logic                            reg_wr,
    input  wire logic                            reg_rd,
    input  wire logic [7:0]                      reg_addr,
    input  wire logic [7:0]                      reg_wdata,
    output logic      [7:0]                      reg_rdata,
    // recording converter samples, one frame per accepted strobe
    input  wire logic                            frame_valid,
    output logic                                 frame_ready,
    input  wire logic [sspc_pkg::SAMPLE_W-1:0]   adc1_left,
    input  wire logic [sspc_pkg::SAMPLE_W-1:0]   adc1_right,
    input  wire logic [sspc_pkg::SAMPLE_W-1:0]   adc2_left,
    input  wire logic [sspc_pkg::SAMPLE_W-1:0]   adc2_right,
    // output filter samples and their enables
    input  wire logic [sspc_pkg::SAMPLE_W-1:0]   filt_left,
    input  wire logic [sspc_pkg::SAMPLE_W-1:0]   filt_right,
    input  wire logic                            left_out_filter_on,
    input  wire logic                            right_out_filter_on,
    // mixed output streams
    output logic                                 out_valid,
    input  wire logic                            out_ready,
    output logic      [sspc_pkg::SAMPLE_W-1:0]   left_output_stream,
    output logic      [sspc_pkg::SAMPLE_W-1:0]   right_output_stream,
    // coefficient read port for the biquad engine
    input  wire logic [3:0]                      coef_rd_index,
    output logic      [15:0]                     coef_rd_value
);
    import sspc_pkg::*;

    localparam int SUM_W = SAMPLE_W + 3;
    localparam int PROD_W = SAMPLE_W + GAIN_W + 1;

    logic       path_on;
    logic       mute;
    logic [1:0] source_pick;
    logic [4:0] level;
    logic [2:0] left_stream_source_mask;
    logic [2:0] right_stream_source_mask;
    logic [7:0] coef_byte_data;
    logic [4:0] coef_byte_addr;
    logic [15:0] coef [COEF_NUM];

    logic       next_path_on;
    logic       next_mute;
    logic [1:0] next_source_pick;
    logic [4:0] next_level;
    logic [2:0] next_left_mask;
    logic [2:0] next_right_mask;
    logic [7:0] next_coef_data;
    logic [4:0] next_coef_addr;
    logic [15:0] next_coef [COEF_NUM];
    logic [7:0] next_rdata;
    logic [15:0] next_coef_rd;

    // register writes; only the index write touches coefficient storage
    always_comb
    begin
        next_path_on = path_on;
        next_mute = mute;
        next_source_pick = source_pick;
        next_level = level;
        next_left_mask = left_stream_source_mask;
        next_right_mask = right_stream_source_mask;
        next_coef_data = coef_byte_data;
        next_coef_addr = coef_byte_addr;
        next_coef = coef;
        if (reg_wr)
        begin
            case (reg_addr)
                OFS_CONTROL:
                begin
                    next_path_on = reg_wdata[BIT_PATH_ON];
                    next_mute = reg_wdata[BIT_MUTE];
                end
                OFS_SOURCE: next_source_pick = reg_wdata[1:0];
                OFS_LEVEL: next_level = reg_wdata[4:0];
                OFS_LEFT_ROUTE: next_left_mask = reg_wdata[2:0];
                OFS_RIGHT_ROUTE: next_right_mask = reg_wdata[2:0];
                OFS_COEF_DATA: next_coef_data = reg_wdata;
                OFS_COEF_INDEX:
                begin
                    next_coef_addr = reg_wdata[4:0];
                    // held byte goes in, data register unchanged
                    if (reg_wdata[0])
                        next_coef[reg_wdata[4:1]][15:8] = coef_byte_data;
                    else
                        next_coef[reg_wdata[4:1]][7:0] = coef_byte_data;
                end
                default: ;
            endcase
        end
    end

    // read mux; reserved bits and unmapped offsets read as zero
    always_comb
    begin
        next_rdata = reg_rdata;
        next_coef_rd = coef[coef_rd_index];
        if (reg_rd)
        begin
            case (reg_addr)
                OFS_CONTROL: next_rdata = {path_on, mute, 6'h00};
                OFS_SOURCE: next_rdata = {6'h00, source_pick};
                OFS_LEVEL: next_rdata = {3'h0, level};
                OFS_LEFT_ROUTE: next_rdata = {5'h00, left_stream_source_mask};
                OFS_RIGHT_ROUTE: next_rdata = {5'h00, right_stream_source_mask};
                OFS_COEF_DATA: next_rdata = coef_byte_data;
                OFS_COEF_INDEX: next_rdata = {3'h0, coef_byte_addr};
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // register state
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            path_on <= RST_PATH_CTRL[1];
            mute <= RST_PATH_CTRL[0];
            source_pick <= RST_SOURCE;
            level <= RST_LEVEL;
            left_stream_source_mask <= RST_LEFT_ROUTE;
            right_stream_source_mask <= RST_RIGHT_ROUTE;
            coef_byte_data <= RST_COEF_DATA;
            coef_byte_addr <= RST_COEF_INDEX;
            coef <= '{default: 16'h0000};
            reg_rdata <= 8'h00;
            coef_rd_value <= 16'h0000;
        end
        else
        begin
            path_on <= next_path_on;
            mute <= next_mute;
            source_pick <= next_source_pick;
            level <= next_level;
            left_stream_source_mask <= next_left_mask;
            right_stream_source_mask <= next_right_mask;
            coef_byte_data <= next_coef_data;
            coef_byte_addr <= next_coef_addr;
            coef <= next_coef;
            reg_rdata <= next_rdata;
            coef_rd_value <= next_coef_rd;
        end
    end

    // clamp a wide sum back to the sample range
    function automatic logic [SAMPLE_W-1:0] saturate(input logic signed [SUM_W-1:0] value);
        logic signed [SUM_W-1:0] top;
        logic signed [SUM_W-1:0] bottom;
        top = SUM_W'(signed'({1'b0, {(SAMPLE_W-1){1'b1}}}));
        bottom = ~top; // most negative sample; a 1-bit signed one would read as minus one
        if (value > top)
            saturate = top[SAMPLE_W-1:0];
        else if (value < bottom)
            saturate = bottom[SAMPLE_W-1:0];
        else
            saturate = value[SAMPLE_W-1:0];
    endfunction

    logic        [SAMPLE_W-1:0]  side_raw;
    logic signed [PROD_W-1:0]    side_prod;
    logic signed [SUM_W-1:0]     side_term;
    logic signed [SUM_W-1:0]     fl_term;
    logic signed [SUM_W-1:0]     fr_term;
    logic signed [SUM_W-1:0]     left_sum;
    logic signed [SUM_W-1:0]     right_sum;
    logic [2*SAMPLE_W-1:0]       mixed;

    // sidestream source, gain and gating; the mix is combinational into the buffer
    always_comb
    begin
        case (source_pick)
            2'h0: side_raw = adc1_left;
            2'h1: side_raw = adc1_right;
            2'h2: side_raw = adc2_left;
            2'h3: side_raw = adc2_right;
            default: side_raw = adc1_left;
        endcase
        side_prod = PROD_W'(signed'(side_raw)) * PROD_W'(signed'({1'b0, GAIN_TABLE[level]}));
        side_term = SUM_W'(side_prod >>> GAIN_FRAC);
        if (!path_on || mute)
            side_term = '0;
        // a filter channel counts only with its enable set
        fl_term = left_out_filter_on ? SUM_W'(signed'(filt_left)) : '0;
        fr_term = right_out_filter_on ? SUM_W'(signed'(filt_right)) : '0;
        left_sum = '0;
        right_sum = '0;
        if (left_stream_source_mask[MASK_LEFT_FILT])
            left_sum = left_sum + fl_term;
        if (left_stream_source_mask[MASK_RIGHT_FILT])
            left_sum = left_sum + fr_term;
        if (left_stream_source_mask[MASK_SIDE])
            left_sum = left_sum + side_term;
        if (right_stream_source_mask[MASK_LEFT_FILT])
            right_sum = right_sum + fl_term;
        if (right_stream_source_mask[MASK_RIGHT_FILT])
            right_sum = right_sum + fr_term;
        if (right_stream_source_mask[MASK_SIDE])
            right_sum = right_sum + side_term;
        mixed = {saturate(left_sum), saturate(right_sum)};
    end

    logic [2*SAMPLE_W-1:0] buffered;

    // a stalled consumer fills the buffer, then frame_ready drops
    sspc_fifo #(
        .WIDTH (2*SAMPLE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_out_fifo (
        .clk       (clk),
        .reset     (reset),
        .in_valid  (frame_valid),
        .in_ready  (frame_ready),
        .in_data   (mixed),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (buffered)
    );

    always_comb
    begin
        left_output_stream = buffered[2*SAMPLE_W-1:SAMPLE_W];
        right_output_stream = buffered[SAMPLE_W-1:0];
    end
endmodule

// *** tb/sspc_asserts.sv ***
`timescale 1ns/1ns
// port-level rules of the register port and the output buffer
module sspc_asserts import sspc_pkg::*; #(
    parameter int FIFO_DEPTH = 4
) (
    // clock and reset
    input wire logic                clk,
    input wire logic                reset,
    // register port
    input wire logic                reg_wr,
    input wire logic                reg_rd,
    input wire logic [7:0]          reg_addr,
    input wire logic [7:0]          reg_wdata,
    input wire logic [7:0]          reg_rdata,
    // stream handshakes
    input wire logic                frame_valid,
    input wire logic                frame_ready,
    input wire logic                out_valid,
    input wire logic                out_ready,
    input wire logic [SAMPLE_W-1:0] left_output_stream,
    input wire logic [SAMPLE_W-1:0] right_output_stream
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic [3:0] occ;
    logic [3:0] next_occ;
    logic [7:0] rsv;
    logic [7:0] shadow [8];
    logic [7:0] next_shadow [8];
    // bits that read as zero; an unmapped offset is all reserved
    assign rsv = (reg_addr == OFS_CONTROL) ? 8'h3f : (reg_addr == OFS_SOURCE) ? 8'hfc :
        (reg_addr == OFS_LEVEL || reg_addr == OFS_COEF_INDEX) ? 8'he0 :
        (reg_addr == OFS_LEFT_ROUTE || reg_addr == OFS_RIGHT_ROUTE) ? 8'hf8 :
        (reg_addr == OFS_COEF_DATA) ? 8'h00 : 8'hff;
    // offsets e4..eb differ in their low three bits, so those index the shadow
    always_comb
    begin
        next_occ = occ + 4'(frame_valid && frame_ready) - 4'(out_valid && out_ready);
        next_shadow = shadow;
        if (reg_wr && rsv != 8'hff)
            next_shadow[reg_addr[2:0]] = reg_wdata;
    end
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            occ <= 4'h0;
            shadow <= '{8'h01, 8'h02, 8'h00, 8'h00, 8'h40, 8'h00, 8'h1c, 8'h00};
        end
        else
        begin
            occ <= next_occ;
            shadow <= next_shadow;
        end
    end
    a_fill_level: assert property (frame_ready == (occ != 4'(FIFO_DEPTH))
        && out_valid == (occ != 4'h0)) else $error("buffer flags wrong");
    a_take_shows: assert property (frame_valid && frame_ready |=> out_valid)
        else $error("taken frame not shown");
    a_head_holds: assert property (out_valid && !out_ready |=> out_valid
        && $stable(left_output_stream) && $stable(right_output_stream)) else $error("head moved");
    a_full_stays: assert property (!frame_ready && !out_ready |=> !frame_ready)
        else $error("full buffer freed itself");
    a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rdata moved");
    a_reserved_zero: assert property (
        reg_rd |=> (reg_rdata & $past(rsv)) == 8'h00) else $error("reserved bits set");
    a_reg_readback: assert property (
        reg_rd && !reg_wr && rsv != 8'hff |=> reg_rdata == ($past(shadow[reg_addr[2:0]])
        & ~$past(rsv))) else $error("register readback wrong");
    a_reset_idle: assert property ($fell(reset) |-> !out_valid && frame_ready
        && reg_rdata == 8'h00) else $error("not idle after reset");
    c_full: cover property (!frame_ready);
    c_pop: cover property (out_valid && out_ready);
    c_data_read: cover property (reg_rd && reg_addr == OFS_COEF_DATA);
endmodule
bind sspc_top sspc_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.clk, .reset, .reg_wr,
    .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .frame_valid, .frame_ready, .out_valid,
    .out_ready, .left_output_stream, .right_output_stream);

// *** tb/sspc_sink.sv ***
`timescale 1ns/1ns
// consumer of the mixed streams; stalls fully or every other cycle
module sspc_sink (
    // clock and reset
    input wire logic        clk,
    input wire logic        reset,
    // stream from the block
    input wire logic        out_valid,
    input wire logic [47:0] word,
    output logic            out_ready,
    // pacing
    input wire logic        hold,
    input wire logic        slow
);
    logic [47:0] got [$];
    logic        phase = 1'b0;
    logic        rdy = 1'b0;
    assign out_ready = rdy;
    // pacing moves on the falling edge so the design samples it settled
    always @(negedge clk)
    begin
        phase <= ~phase;
        rdy <= !reset && !hold && (!slow || phase);
    end
    always @(posedge clk)
        if (!reset && out_valid && out_ready)
            got.push_back(word);
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
    import sspc_pkg::*;
    localparam logic [7:0] RV [8] = '{8'h40, 8'h00, 8'h1c, 8'h00, 8'h01, 8'h02, 8'h00, 8'h00};
    localparam logic [7:0] FV [8] = '{8'hc0, 8'h03, 8'h1f, 8'h00, 8'h07, 8'h07, 8'hff, 8'h1f};
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic [7:0]  reg_rdata;
    logic        frame_valid = 1'b0;
    logic        frame_ready;
    logic        out_valid;
    logic        out_ready;
    logic [23:0] a = 24'h0;
    logic [23:0] fl = 24'h0;
    logic [23:0] fr = 24'h0;
    logic [23:0] lo;
    logic [23:0] ro;
    logic        onl = 1'b1;
    logic        onr = 1'b1;
    logic        hold = 1'b0;
    logic        slow = 1'b0;
    logic [3:0]  cidx = 4'h0;
    logic [15:0] cval;
    logic [7:0]  mir [8] = '{8'h01, 8'h02, 8'h00, 8'h00, 8'h40, 8'h00, 8'h1c, 8'h00};
    logic [47:0] exp_q [$];
    int          err_count = 0;
    int          checks = 0;
    // each converter input carries the base sample plus its number
    sspc_top #(.FIFO_DEPTH(4)) dut (.clk, .reset, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .frame_valid, .frame_ready, .adc1_left(a), .adc1_right(a + 24'h1),
        .adc2_left(a + 24'h2), .adc2_right(a + 24'h3), .filt_left(fl), .filt_right(fr),
        .left_out_filter_on(onl), .right_out_filter_on(onr), .out_valid, .out_ready,
        .left_output_stream(lo), .right_output_stream(ro), .coef_rd_index(cidx),
        .coef_rd_value(cval));
    sspc_sink sink (.clk, .reset, .out_valid, .word({lo, ro}), .out_ready, .hold, .slow);
    always #20 clk = ~clk;
    task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
        checks++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // register cycles: one strobe cycle, then a quiet edge before the next
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = ad;
        reg_wdata = d;
        mir[ad[2:0]] = d;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = ad;
        @(negedge clk);
        reg_rd = 1'b0;
        check($sformatf("reg %h", ad), {40'h0, exp}, {40'h0, reg_rdata});
    endtask
    task automatic coef(input logic [3:0] i, input logic [15:0] exp);
        @(negedge clk);
        cidx = i;
        @(negedge clk);
        check("coef", {32'h0, exp}, {32'h0, cval});
    endtask
    function automatic logic [23:0] side(input logic [23:0] x, input logic [4:0] g);
        logic signed [47:0] p;
        p = $signed(x) * $signed({1'b0, GAIN_TABLE[g]});
        return p[37:14];
    endfunction
    // sum of the selected terms, clipped to the sample range
    function automatic logic [23:0] mix(input logic [2:0] m, input logic [23:0] sd);
        int s;
        s = 0;
        if (m[0] && onl)
            s += $signed(fl);
        if (m[1] && onr)
            s += $signed(fr);
        if (m[2])
            s += $signed(sd);
        s = (s > 8388607) ? 8388607 : (s < -8388608) ? -8388608 : s;
        return s[23:0];
    endfunction
    task automatic frame(input logic [23:0] base, input logic [23:0] l, input logic [23:0] r);
        logic [23:0] sd;
        @(negedge clk);
        a = base;
        fl = l;
        fr = r;
        sd = (mir[4][7] && !mir[4][6]) ? side(base + 24'(mir[5][1:0]), mir[6][4:0]) : 24'h0;
        exp_q.push_back({mix(mir[0][2:0], sd), mix(mir[1][2:0], sd)});
        frame_valid = 1'b1;
        while (frame_ready !== 1'b1)
            @(negedge clk);
        @(negedge clk);
        frame_valid = 1'b0;
    endtask
    task automatic drain();
        repeat (40) @(negedge clk);
        check("word count", 48'(exp_q.size()), 48'(sink.got.size()));
        while (exp_q.size() > 0 && sink.got.size() > 0)
            check("stream pair", exp_q.pop_front(), sink.got.pop_front());
        exp_q.delete();
        sink.got.delete();
    endtask
    initial
    begin
        repeat (6) @(negedge clk);
        reset = 1'b0;
        for (int k = 0; k < 8; k++)
            rd(8'he4 + 8'(k), RV[k]);
        frame(24'h5, 24'h111, 24'h222);
        drain();
        for (int k = 0; k < 8; k++)
            wr(8'he4 + 8'(k), 8'hff);
        for (int k = 0; k < 8; k++)
            rd(8'he4 + 8'(k), FV[k]);
        coef(4'hf, 16'hff00);
        wr(OFS_COEF_DATA, 8'h34);
        wr(OFS_COEF_INDEX, 8'h04);
        wr(OFS_COEF_DATA, 8'h12);
        wr(OFS_COEF_INDEX, 8'h05);
        wr(OFS_COEF_DATA, 8'h99);
        coef(4'h2, 16'h1234);
        wr(OFS_COEF_INDEX, 8'h06);
        wr(OFS_COEF_INDEX, 8'h07);
        coef(4'h3, 16'h9999);
        wr(OFS_CONTROL, 8'h80);
        wr(OFS_LEFT_ROUTE, 8'h04);
        for (int k = 0; k < 32; k++)
        begin
            wr(OFS_SOURCE, 8'(k % 4));
            wr(OFS_LEVEL, 8'(k));
            frame(24'h010000, 24'h000100, 24'h000010);
        end
        drain();
        wr(OFS_CONTROL, 8'hc0);
        frame(24'h2000, 24'h1, 24'h2);
        wr(OFS_CONTROL, 8'h00);
        frame(24'h3000, 24'h1, 24'h2);
        drain();
        wr(OFS_CONTROL, 8'h80);
        wr(OFS_LEFT_ROUTE, 8'h03);
        onl = 1'b0;
        frame(24'h40, 24'h300, 24'h500);
        onl = 1'b1;
        onr = 1'b0;
        frame(24'h40, 24'h300, 24'h500);
        onr = 1'b1;
        frame(24'h0, 24'h7fffff, 24'h7fffff);
        frame(24'h0, 24'h800000, 24'h800000);
        drain();
        hold = 1'b1;
        for (int k = 0; k < 4; k++)
            frame(24'(k * 64), 24'h10, 24'h20);
        check("frame_ready when full", 48'h0, {47'h0, frame_ready});
        slow = 1'b1;
        hold = 1'b0;
        frame(24'h500, 24'h10, 24'h20);
        drain();
        give_verdict();
    end
    initial
    begin
        #(40 * 20000);
        err_count++;
        give_verdict();
    end
endmodule
